/* rtl/mab_addr_stage.sv */
// Purpose: Address and control output stage of the external memory bus
// Assumes: mem_clk_i is the memory bus clock, unrelated to clk_i
// Notes: One word access in flight; buffered writes go ahead of direct ones
//
// Functional notes
// - Pipeline enable high: outputs change in high phase, low: next low phase.
// - Enhanced mode: low address lines carry byte-mask bits two and three.
// - Byte-mask bits active low; mark needed or valid byte lanes.
// - Standard mode: low address lines carry low two byte-address bits.
// - Address lines 31..2 always carry upper thirty byte-address bits.
// - Address bus enable low floats address, direction, size, line-fill, lock.
// - Abort sampled only during an external access, ignored otherwise.
// - Eight-entry write buffer of one to sixteen bytes, with drain operation.
// - Standard mode size lanes: 2 word, 1 halfword, 0 byte.
// - Enhanced mode size lanes carry byte-mask bits zero and one.
`default_nettype none

module mab_addr_stage
	import mab_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic mem_clk_i,
	input wire logic req_valid_i,
	output logic req_ready_o,
	input wire logic [31:0] req_addr_i,
	input wire logic [31:0] req_wdata_i,
	input wire logic req_write_i,
	input wire logic req_buffered_i,
	input wire mab_size_t req_size_i,
	input wire logic req_line_fill_i,
	input wire logic req_lock_i,
	output logic rsp_valid_o,
	output logic rsp_abort_o,
	output logic wb_abort_o,
	input wire logic drain_i,
	output logic drain_busy_o,
	output logic wb_empty_o,
	input wire logic address_pipeline_enable_i,
	input wire logic address_bus_enable_i,
	input wire logic bus_mode_i,
	input wire logic abort_i,
	input wire logic [3:0] core_clock_strap_i,
	output logic [3:0] core_clock_cfg_o,
	output logic [31:0] address_o,
	output logic write_not_read_o,
	output logic [1:0] access_size_lanes_o,
	output logic line_fill_flag_o,
	output logic lock_o,
	output logic addr_phase_oe_o,
	output logic [31:0] wdata_o
);

	// ----------------------------------------
	// Core domain: straps and mode
	// ----------------------------------------
	logic [3:0] strap_s, strap_q;
	logic [1:0] strap_wait_q;
	logic enh_core_s;

	mab_sync2 #(.W(5)) u_strap_sync (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.d_i({bus_mode_i, core_clock_strap_i}),
		.q_o({enh_core_s, strap_s})
	);

	// Sync output is stale for two edges; later strap changes are not followed
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			strap_wait_q <= 2'h0;
			strap_q <= 4'h0;
		end
		else if (strap_wait_q != 2'h3)
		begin
			strap_wait_q <= strap_wait_q + 2'h1;
			strap_q <= strap_s;
		end
	end

	assign core_clock_cfg_o = strap_q;

	// ----------------------------------------
	// Core domain: write buffer and issue control
	// ----------------------------------------
	mab_core_state_t c_state_q;
	mab_access_t hs_word_q;
	mab_wb_entry_t head;
	logic [1:0] wb_word_q;
	logic src_buf_q, req_tgl_q, drain_q, rsp_valid_q, rsp_abort_q, wb_abort_q, head_valid;
	logic wb_ready, wb_empty, ack_tgl_s, ack_seen_q, ack_tgl_q, ack_abort_q;

	wire [3:0] dir_be = (req_size_i == MAB_SZ_WORD) ? 4'hf :
		(req_size_i == MAB_SZ_HALF) ? (req_addr_i[1] ? 4'hc : 4'h3) :
		4'(4'h1 << req_addr_i[1:0]);
	wire push_valid = req_valid_i && req_buffered_i && req_write_i;
	wire direct_req = req_valid_i && !(req_buffered_i && req_write_i);
	// Direct access waits for the buffer so reads never pass older writes
	wire direct_go = direct_req && (c_state_q == MAB_C_IDLE) && wb_empty;
	wire [3:0] head_nib = head.be[{wb_word_q, 2'b00} +: 4];
	wire [31:0] head_dat = head.data[{wb_word_q, 5'b00000} +: 32];
	wire buf_turn = (c_state_q == MAB_C_IDLE) && head_valid;
	wire buf_go = buf_turn && (head_nib != 4'h0);
	wire ack_edge = (ack_tgl_s != ack_seen_q);
	wire word_done = (buf_turn && (head_nib == 4'h0))
		|| ((c_state_q == MAB_C_WAIT) && ack_edge && src_buf_q);
	wire pop = word_done && (wb_word_q == 2'h3);
	wire [1:0] head_size = (head_nib == 4'hf) ? MAB_SZ_WORD :
		((head_nib == 4'h3) || (head_nib == 4'hc)) ? MAB_SZ_HALF : MAB_SZ_BYTE;
	wire [1:0] head_low = head_nib[0] ? 2'h0 : head_nib[1] ? 2'h1 :
		head_nib[2] ? 2'h2 : 2'h3;

	mab_write_buffer u_wbuf (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.push_valid_i(push_valid),
		.push_ready_o(wb_ready),
		.push_addr_i(req_addr_i),
		.push_data_i(req_wdata_i),
		.push_be_i(dir_be),
		.merge_en_i(enh_core_s),
		.head_valid_o(head_valid),
		.head_o(head),
		.pop_i(pop),
		.empty_o(wb_empty)
	);

	mab_sync2 #(.W(1)) u_ack_sync (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.d_i(ack_tgl_q),
		.q_o(ack_tgl_s)
	);

	assign req_ready_o = push_valid ? wb_ready : direct_go;

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			c_state_q <= MAB_C_IDLE;
			wb_word_q <= 2'h0;
			src_buf_q <= 1'b0;
			req_tgl_q <= 1'b0;
			hs_word_q <= '0;
			ack_seen_q <= 1'b0;
			rsp_valid_q <= 1'b0;
			rsp_abort_q <= 1'b0;
			wb_abort_q <= 1'b0;
		end
		else
		begin
			rsp_valid_q <= 1'b0;
			wb_abort_q <= 1'b0;
			if (word_done)
				wb_word_q <= wb_word_q + 2'h1;
			case (c_state_q)
				MAB_C_IDLE:
				begin
					if (buf_go)
					begin
						hs_word_q <= '{addr: {head.blk, wb_word_q, head_low}, wdata: head_dat,
							be: head_nib, size: mab_size_t'(head_size), write: 1'b1,
							line_fill: 1'b0, lock: 1'b0};
						src_buf_q <= 1'b1;
						req_tgl_q <= ~req_tgl_q;
						c_state_q <= MAB_C_WAIT;
					end
					else if (direct_go)
					begin
						hs_word_q <= '{addr: req_addr_i, wdata: req_wdata_i, be: dir_be,
							size: req_size_i, write: req_write_i,
							line_fill: req_line_fill_i, lock: req_lock_i};
						src_buf_q <= 1'b0;
						req_tgl_q <= ~req_tgl_q;
						c_state_q <= MAB_C_WAIT;
					end
				end
				MAB_C_WAIT:
				begin
					if (ack_edge)
					begin
						ack_seen_q <= ack_tgl_s;
						rsp_valid_q <= !src_buf_q;
						rsp_abort_q <= src_buf_q ? rsp_abort_q : ack_abort_q;
						wb_abort_q <= src_buf_q && ack_abort_q;
						c_state_q <= MAB_C_IDLE;
					end
				end
				default:
					c_state_q <= MAB_C_IDLE;
			endcase
		end
	end

	// Drain completes once the buffer is empty and no access, buffered or direct, is in flight
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			drain_q <= 1'b0;
		else if (drain_i)
			drain_q <= 1'b1;
		else if (wb_empty && (c_state_q == MAB_C_IDLE))
			drain_q <= 1'b0;
	end

	assign drain_busy_o = drain_q;
	assign wb_empty_o = wb_empty;
	assign rsp_valid_o = rsp_valid_q;
	assign rsp_abort_o = rsp_abort_q;
	assign wb_abort_o = wb_abort_q;

	// ----------------------------------------
	// Memory clock domain
	// ----------------------------------------
	logic mrst_b, ape_s, abe_s, enh_s, abort_s, req_tgl_s, req_seen_q, abort_hit_q;
	logic [2:0] acc_cnt_q;
	mab_mem_state_t m_state_q;
	mab_access_t cur_q;
	logic [31:0] hi_addr_q, lo_addr_q, wdata_q;
	logic [5:0] hi_ctl_q, lo_ctl_q;

	mab_sync2 #(.W(1)) u_mrst_sync (
		.clk_i(mem_clk_i),
		.rst_b_i(rst_b_i),
		.d_i(1'b1),
		.q_o(mrst_b)
	);

	mab_sync2 #(.W(5)) u_pin_sync (
		.clk_i(mem_clk_i),
		.rst_b_i(mrst_b),
		.d_i({address_pipeline_enable_i, address_bus_enable_i, bus_mode_i, abort_i,
			req_tgl_q}),
		.q_o({ape_s, abe_s, enh_s, abort_s, req_tgl_s})
	);

	// Active-low mask; enhanced mode splits it over address and size lanes
	wire [3:0] mask_n = ~cur_q.be;
	wire [1:0] low_lines = enh_s ? mask_n[3:2] : cur_q.addr[1:0];
	wire [1:0] size_lines = enh_s ? mask_n[1:0] : cur_q.size;
	wire [31:0] next_addr = {cur_q.addr[31:2], low_lines};

	always_ff @(posedge mem_clk_i or negedge mrst_b)
	begin
		if (!mrst_b)
		begin
			m_state_q <= MAB_M_IDLE;
			req_seen_q <= 1'b0;
			ack_tgl_q <= 1'b0;
			ack_abort_q <= 1'b0;
			abort_hit_q <= 1'b0;
			acc_cnt_q <= 3'h0;
			cur_q <= '0;
			hi_addr_q <= 32'h0;
			hi_ctl_q <= 6'h00;
			wdata_q <= 32'h0;
		end
		else
		begin
			case (m_state_q)
				MAB_M_IDLE:
				begin
					if (req_tgl_s != req_seen_q)
					begin
						req_seen_q <= req_tgl_s;
						cur_q <= hs_word_q;
						m_state_q <= MAB_M_ADDR;
					end
				end
				MAB_M_ADDR:
				begin
					hi_addr_q <= next_addr;
					hi_ctl_q <= {cur_q.write, size_lines, cur_q.line_fill, cur_q.lock, 1'b0};
					wdata_q <= cur_q.wdata;
					abort_hit_q <= 1'b0;
					acc_cnt_q <= 3'h0;
					m_state_q <= MAB_M_ACCESS;
				end
				MAB_M_ACCESS:
				begin
					if (abort_s)
						abort_hit_q <= 1'b1;
					acc_cnt_q <= acc_cnt_q + 3'h1;
					if (acc_cnt_q == `MAB_ACCESS_CYCLES - 3'h1)
						m_state_q <= MAB_M_DONE;
				end
				MAB_M_DONE:
				begin
					ack_abort_q <= abort_hit_q;
					ack_tgl_q <= ~ack_tgl_q;
					m_state_q <= MAB_M_IDLE;
				end
				default:
					m_state_q <= MAB_M_IDLE;
			endcase
		end
	end

	// Low-phase copy holds the change to the following low period
	always_ff @(negedge mem_clk_i or negedge mrst_b)
	begin
		if (!mrst_b)
		begin
			lo_addr_q <= 32'h0;
			lo_ctl_q <= 6'h00;
		end
		else
		begin
			lo_addr_q <= hi_addr_q;
			lo_ctl_q <= hi_ctl_q;
		end
	end

	// Pipeline enable is a strap, so switching the source never glitches in use
	wire [31:0] out_addr = ape_s ? hi_addr_q : lo_addr_q;
	wire [5:0] out_ctl = ape_s ? hi_ctl_q : lo_ctl_q;

	assign address_o = out_addr;
	assign write_not_read_o = out_ctl[5];
	assign access_size_lanes_o = out_ctl[4:3];
	assign line_fill_flag_o = out_ctl[2];
	assign lock_o = out_ctl[1];
	assign addr_phase_oe_o = abe_s;
	assign wdata_o = wdata_q;

endmodule

`default_nettype wire

/* rtl/mab_params.svh */
// Purpose: Shared constants of the memory bus address stage
// Assumes: Included by the package only
// Notes: Sizes follow the standard-mode size lane encoding
`ifndef MAB_PARAMS_SVH
`define MAB_PARAMS_SVH

// ----------------------------------------
// Write buffer geometry
// ----------------------------------------
`define MAB_WB_DEPTH 8
`define MAB_WB_PTR_W 3
`define MAB_WB_CNT_W 4
`define MAB_WB_BYTES 16
`define MAB_WB_BLK_W 28

// ----------------------------------------
// Size lane codes and access timing
// ----------------------------------------
`define MAB_SIZE_BYTE 2'h0
`define MAB_SIZE_HALF 2'h1
`define MAB_SIZE_WORD 2'h2
`define MAB_ACCESS_CYCLES 3'h2

`endif

/* rtl/mab_pkg.sv */
// Purpose: Types of the memory bus address stage
// Assumes: mab_params.svh holds every size, width and timing number; state codes are set here
// Notes: None
`default_nettype none
`include "mab_params.svh"

package mab_pkg;

	typedef enum logic [1:0]
	{
		MAB_SZ_BYTE = `MAB_SIZE_BYTE,
		MAB_SZ_HALF = `MAB_SIZE_HALF,
		MAB_SZ_WORD = `MAB_SIZE_WORD
	} mab_size_t;

	// One word access passed from the core domain to the memory clock domain
	typedef struct packed
	{
		logic [31:0] addr;
		logic [31:0] wdata;
		logic [3:0] be;
		mab_size_t size;
		logic write;
		logic line_fill;
		logic lock;
	} mab_access_t;

	typedef struct packed
	{
		logic [`MAB_WB_BLK_W-1:0] blk;
		logic [8*`MAB_WB_BYTES-1:0] data;
		logic [`MAB_WB_BYTES-1:0] be;
	} mab_wb_entry_t;

	typedef enum logic {MAB_C_IDLE = 1'b0, MAB_C_WAIT = 1'b1} mab_core_state_t;

	typedef enum logic [1:0]
	{
		MAB_M_IDLE = 2'b00,
		MAB_M_ADDR = 2'b01,
		MAB_M_ACCESS = 2'b11,
		MAB_M_DONE = 2'b10
	} mab_mem_state_t;

endpackage

`default_nettype wire

/* rtl/mab_sync2.sv */
// Purpose: Two-flop level synchroniser
// Assumes: Reset value is zero
// Notes: First stage feeds only the second
`default_nettype none

module mab_sync2 #(
	parameter int W = 1
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);

	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			meta_q <= '0;
			sync_q <= '0;
		end
		else
		begin
			meta_q <= d_i;
			sync_q <= meta_q;
		end
	end

	assign q_o = sync_q;

endmodule

`default_nettype wire

/* rtl/mab_write_buffer.sv */
// Purpose: Eight-entry write buffer, up to sixteen bytes per entry
// Assumes: Head entry is drained word by word by the owner
// Notes: Merging never touches the head entry
`default_nettype none

module mab_write_buffer
	import mab_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic push_valid_i,
	output logic push_ready_o,
	input wire logic [31:0] push_addr_i,
	input wire logic [31:0] push_data_i,
	input wire logic [3:0] push_be_i,
	input wire logic merge_en_i,
	output logic head_valid_o,
	output mab_wb_entry_t head_o,
	input wire logic pop_i,
	output logic empty_o
);

	mab_wb_entry_t mem_q [`MAB_WB_DEPTH];
	logic [`MAB_WB_PTR_W-1:0] wr_ptr_q;
	logic [`MAB_WB_PTR_W-1:0] rd_ptr_q;
	logic [`MAB_WB_CNT_W-1:0] count_q;

	wire [`MAB_WB_PTR_W-1:0] tail_idx = wr_ptr_q - `MAB_WB_PTR_W'(1);
	wire [`MAB_WB_BLK_W-1:0] push_blk = push_addr_i[31:4];
	// Head is being drained, so merging starts from the second entry
	wire merge_hit = merge_en_i && (count_q > `MAB_WB_CNT_W'(1))
		&& (mem_q[tail_idx].blk == push_blk);
	wire full = (count_q == `MAB_WB_CNT_W'(`MAB_WB_DEPTH));
	wire push_fire = push_valid_i && push_ready_o;
	wire push_new = push_fire && !merge_hit;
	wire pop_fire = pop_i && !empty_o;
	wire [`MAB_WB_BYTES-1:0] lane_be =
		`MAB_WB_BYTES'({12'h000, push_be_i} << {push_addr_i[3:2], 2'b00});
	wire [8*`MAB_WB_BYTES-1:0] lane_data =
		(8*`MAB_WB_BYTES)'({96'h0, push_data_i} << {push_addr_i[3:2], 5'b00000});
	wire [8*`MAB_WB_BYTES-1:0] lane_bits;

	assign push_ready_o = merge_hit || !full;
	assign empty_o = (count_q == `MAB_WB_CNT_W'(0));
	assign head_valid_o = !empty_o;
	assign head_o = mem_q[rd_ptr_q];

	genvar b;
	genvar e;
	generate
		for (b = 0; b < `MAB_WB_BYTES; b++)
		begin : g_lane
			assign lane_bits[8*b +: 8] = {8{lane_be[b]}};
		end
		for (e = 0; e < `MAB_WB_DEPTH; e++)
		begin : g_entry
			wire hit_new = push_new && (wr_ptr_q == `MAB_WB_PTR_W'(e));
			wire hit_mrg = push_fire && merge_hit && (tail_idx == `MAB_WB_PTR_W'(e));
			always_ff @(posedge clk_i or negedge rst_b_i)
			begin
				if (!rst_b_i)
					mem_q[e] <= '0;
				else if (hit_new)
				begin
					mem_q[e].blk <= push_blk;
					mem_q[e].be <= lane_be;
					mem_q[e].data <= lane_data;
				end
				else if (hit_mrg)
				begin
					mem_q[e].be <= mem_q[e].be | lane_be;
					mem_q[e].data <= (mem_q[e].data & ~lane_bits) | (lane_data & lane_bits);
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
		end
		else
		begin
			if (push_new)
				wr_ptr_q <= wr_ptr_q + `MAB_WB_PTR_W'(1);
			if (pop_fire)
				rd_ptr_q <= rd_ptr_q + `MAB_WB_PTR_W'(1);
			count_q <= count_q + `MAB_WB_CNT_W'(push_new) - `MAB_WB_CNT_W'(pop_fire);
		end
	end

endmodule

`default_nettype wire

/* verif/mab_addr_stage_sva.sv */
// Purpose: Port assertions of the address stage
// Assumes: Strap and mode pins change only during reset
// Notes: Two clock domains, each with its own clock per property
`default_nettype none

module mab_addr_stage_sva
(
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic mem_clk_i,
	input wire logic req_valid_i,
	input wire logic req_write_i,
	input wire logic req_buffered_i,
	input wire logic req_ready_o,
	input wire logic rsp_valid_o,
	input wire logic rsp_abort_o,
	input wire logic wb_abort_o,
	input wire logic wb_empty_o,
	input wire logic drain_busy_o,
	input wire logic address_pipeline_enable_i,
	input wire logic address_bus_enable_i,
	input wire logic bus_mode_i,
	input wire logic [3:0] core_clock_strap_i,
	input wire logic [3:0] core_clock_cfg_o,
	input wire logic [31:0] address_o,
	input wire logic [1:0] access_size_lanes_o,
	input wire logic addr_phase_oe_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----
	// Helper logic
	// ----
	logic [31:0] pos_q;
	logic [31:0] neg_q;
	logic [2:0] cnt_q;
	always_ff @(posedge mem_clk_i or negedge rst_b_i)
		if (!rst_b_i)
			pos_q <= '0;
		else
			pos_q <= address_o;
	always_ff @(negedge mem_clk_i or negedge rst_b_i)
		if (!rst_b_i)
			neg_q <= '0;
		else
			neg_q <= address_o;
	always_ff @(posedge clk_i or negedge rst_b_i)
		if (!rst_b_i)
			cnt_q <= '0;
		else if (cnt_q != 3'h7)
			cnt_q <= cnt_q + 3'h1;
	// ----
	// Assertions
	// ----
	ape_high_a: assert property (@(posedge mem_clk_i) disable iff (!rst_b_i)
		address_pipeline_enable_i |-> address_o == neg_q) else $error("addr moved while clock low");
	ape_low_a: assert property (@(negedge mem_clk_i) disable iff (!rst_b_i)
		!address_pipeline_enable_i |-> address_o == pos_q) else $error("addr moved while clock high");
	float_on_a: assert property (@(posedge mem_clk_i) disable iff (!rst_b_i)
		!address_bus_enable_i [*3] |-> !addr_phase_oe_o) else $error("address group still driven");
	drive_on_a: assert property (@(posedge mem_clk_i) disable iff (!rst_b_i)
		address_bus_enable_i [*6] |-> addr_phase_oe_o) else $error("address group not driven");
	std_size_a: assert property (@(posedge mem_clk_i) disable iff (!rst_b_i)
		!bus_mode_i |-> access_size_lanes_o != 2'h3) else $error("bad size code");
	enh_mask_a: assert property (@(posedge mem_clk_i) disable iff (!rst_b_i)
		bus_mode_i |-> {address_o[1:0], access_size_lanes_o} != 4'hf) else $error("empty mask");
	direct_wait_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		req_valid_i && !(req_write_i && req_buffered_i) && !wb_empty_o |-> !req_ready_o)
		else $error("direct access passed buffer");
	rsp_pulse_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		rsp_valid_o |=> !rsp_valid_o) else $error("response longer than one cycle");
	abort_hold_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		$changed(rsp_abort_o) |-> rsp_valid_o) else $error("abort status changed alone");
	strap_cfg_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		cnt_q == 3'h7 |-> core_clock_cfg_o == core_clock_strap_i) else $error("strap not captured");
	abort_seen_c: cover property (@(posedge clk_i) rsp_valid_o && rsp_abort_o);
	wb_abort_c: cover property (@(posedge clk_i) wb_abort_o);
	drain_end_c: cover property (@(posedge clk_i) $fell(drain_busy_o));
endmodule

`default_nettype wire

/* verif/mab_mem_model.sv */
// Purpose: Memory controller model that answers with abort
// Assumes: Abort is raised only when the bench asks for it
// Notes: Abort is driven from the memory clock like the real controller
`default_nettype none

module mab_mem_model
(
	input wire logic mem_clk_i,
	input wire logic rst_b_i,
	input wire logic abort_cmd_i,
	output logic abort_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----
	// Abort reporting
	// ----
	// Registered on the bus clock so the stage must resynchronise it
	always_ff @(posedge mem_clk_i or negedge rst_b_i)
		if (!rst_b_i)
			abort_o <= 1'b0;
		else
			abort_o <= abort_cmd_i;
endmodule

`default_nettype wire

/* verif/tb.sv */
// Purpose: Self-checking bench of the address stage
// Assumes: Static pins are changed only while reset is held
// Notes: Inputs move on the falling clock edge
`default_nettype none

`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_fail++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end

module tb
	import mab_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 1'b0, rst_b_i = 1'b0, mem_clk_i = 1'b0, abort_i, abort_cmd = 1'b0;
	logic req_valid_i = 1'b0, req_write_i = 1'b0, req_buffered_i = 1'b0, drain_i = 1'b0;
	logic req_line_fill_i = 1'b0, req_lock_i = 1'b0, bus_mode_i = 1'b0;
	logic address_pipeline_enable_i = 1'b1, address_bus_enable_i = 1'b1;
	logic [31:0] req_addr_i = '0, req_wdata_i = '0, address_o, wdata_o;
	logic [3:0] core_clock_strap_i = 4'ha, core_clock_cfg_o;
	mab_size_t req_size_i = MAB_SZ_WORD;
	logic req_ready_o, rsp_valid_o, rsp_abort_o, wb_abort_o, drain_busy_o, wb_empty_o;
	logic write_not_read_o, line_fill_flag_o, lock_o, addr_phase_oe_o;
	logic [1:0] access_size_lanes_o;
	int n_fail = 0, cmp_count = 0;

	mab_addr_stage mab_addr_stage_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .mem_clk_i(mem_clk_i),
		.req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .req_addr_i(req_addr_i),
		.req_wdata_i(req_wdata_i), .req_write_i(req_write_i), .req_buffered_i(req_buffered_i),
		.req_size_i(req_size_i), .req_line_fill_i(req_line_fill_i), .req_lock_i(req_lock_i),
		.rsp_valid_o(rsp_valid_o), .rsp_abort_o(rsp_abort_o), .wb_abort_o(wb_abort_o),
		.drain_i(drain_i), .drain_busy_o(drain_busy_o), .wb_empty_o(wb_empty_o),
		.address_pipeline_enable_i(address_pipeline_enable_i),
		.address_bus_enable_i(address_bus_enable_i), .bus_mode_i(bus_mode_i),
		.abort_i(abort_i), .core_clock_strap_i(core_clock_strap_i),
		.core_clock_cfg_o(core_clock_cfg_o), .address_o(address_o),
		.write_not_read_o(write_not_read_o), .access_size_lanes_o(access_size_lanes_o),
		.line_fill_flag_o(line_fill_flag_o), .lock_o(lock_o),
		.addr_phase_oe_o(addr_phase_oe_o), .wdata_o(wdata_o));
	mab_mem_model mab_mem_model_i (.mem_clk_i(mem_clk_i), .rst_b_i(rst_b_i),
		.abort_cmd_i(abort_cmd), .abort_o(abort_i));

	initial forever #10 clk_i = ~clk_i;
	initial
	begin
		#3;
		forever #7.5 mem_clk_i = ~mem_clk_i;
	end

	// ----
	// Tasks
	// ----
	task automatic do_reset(input logic address_pipeline_enable, input logic mode);
		@(negedge clk_i);
		rst_b_i = 1'b0;
		address_pipeline_enable_i = address_pipeline_enable;
		bus_mode_i = mode;
		repeat (4) @(negedge clk_i);
		rst_b_i = 1'b1;
		repeat (4) @(negedge clk_i);
	endtask

	task automatic access(input logic [31:0] a, input logic wr, bf, input mab_size_t sz,
		input logic ab);
		logic [3:0] be;
		logic rdy;
		be = (sz == MAB_SZ_WORD) ? 4'hf : (sz == MAB_SZ_HALF) ? 4'h3 << {a[1], 1'b0} :
			4'h1 << a[1:0];
		req_addr_i = a;
		req_wdata_i = ~a;
		req_write_i = wr;
		req_buffered_i = bf;
		req_size_i = sz;
		req_line_fill_i = a[2];
		req_lock_i = a[3];
		req_valid_i = 1'b1;
		rdy = 1'b0;
		// Ready counts only at the rising edge that takes the request
		for (int i = 0; i < 300 && !rdy; i++)
		begin
			@(posedge clk_i);
			rdy = req_ready_o;
		end
		@(negedge clk_i);
		req_valid_i = 1'b0;
		`CHK(rdy, 1'b1)
		if (!(wr && bf))
		begin
			for (int i = 0; i < 300 && !rsp_valid_o; i++) @(negedge clk_i);
			`CHK(rsp_valid_o, 1'b1)
			`CHK(rsp_abort_o, ab)
			`CHK(address_o[31:2], a[31:2])
			`CHK({write_not_read_o, line_fill_flag_o, lock_o}, {wr, a[2], a[3]})
			if (bus_mode_i)
				`CHK({address_o[1:0], access_size_lanes_o}, ~be)
			else
				`CHK({address_o[1:0], access_size_lanes_o}, {a[1:0], sz})
			if (wr)
				`CHK(wdata_o, ~a)
		end
		else
			@(negedge clk_i);
	endtask

	task automatic size_sweep(input logic [31:0] base);
		for (int s = 0; s < 6; s++)
			access(base + 32'((s % 3 == 2) ? 0 : 3 - s % 3) + 32'(s * 16), s[0], 1'b0,
				mab_size_t'(s % 3), 1'b0);
	endtask

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// ----
	// Tests
	// ----
	initial
	begin
		do_reset(1'b1, 1'b0);
		`CHK(core_clock_cfg_o, 4'ha)
		size_sweep(32'h8000_1000);
		$display("test standard sizes done");
		address_bus_enable_i = 1'b0;
		repeat (4) @(negedge clk_i);
		`CHK(addr_phase_oe_o, 1'b0)
		address_bus_enable_i = 1'b1;
		repeat (4) @(negedge clk_i);
		`CHK(addr_phase_oe_o, 1'b1)
		$display("test float done");
		abort_cmd = 1'b1;
		repeat (20) @(negedge clk_i);
		abort_cmd = 1'b0;
		repeat (10) @(negedge clk_i);
		access(32'h4000_0010, 1'b0, 1'b0, MAB_SZ_WORD, 1'b0);
		abort_cmd = 1'b1;
		access(32'h4000_0020, 1'b0, 1'b0, MAB_SZ_WORD, 1'b1);
		abort_cmd = 1'b0;
		$display("test abort done");
		do_reset(1'b0, 1'b1);
		size_sweep(32'h9000_2000);
		for (int w = 0; w < 4; w++)
			access(32'h2000_0000 + 32'(w * 4 + w), 1'b1, 1'b1, MAB_SZ_BYTE, 1'b0);
		drain_i = 1'b1;
		@(negedge clk_i);
		drain_i = 1'b0;
		access(32'h2000_0100, 1'b0, 1'b0, MAB_SZ_HALF, 1'b0);
		for (int i = 0; i < 300 && drain_busy_o; i++) @(negedge clk_i);
		`CHK({drain_busy_o, wb_empty_o}, 2'h1)
		abort_cmd = 1'b1;
		access(32'h2000_0200, 1'b1, 1'b1, MAB_SZ_WORD, 1'b1);
		for (int i = 0; i < 300 && !wb_abort_o; i++) @(negedge clk_i);
		abort_cmd = 1'b0;
		`CHK(wb_abort_o, 1'b1)
		`CHK(address_o, 32'h2000_0200)
		`CHK({write_not_read_o, access_size_lanes_o}, 3'h4)
		`CHK(wdata_o, ~32'h2000_0200)
		$display("test enhanced and drain done");
		print_verdict();
	end

	initial
	begin
		#200us;
		n_fail++;
		print_verdict();
	end
endmodule

bind mab_addr_stage mab_addr_stage_sva mab_addr_stage_sva_i (.clk_i(clk_i), .rst_b_i(rst_b_i),
	.mem_clk_i(mem_clk_i), .req_valid_i(req_valid_i), .req_write_i(req_write_i),
	.req_buffered_i(req_buffered_i), .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
	.rsp_abort_o(rsp_abort_o), .wb_abort_o(wb_abort_o), .wb_empty_o(wb_empty_o),
	.drain_busy_o(drain_busy_o), .address_pipeline_enable_i(address_pipeline_enable_i),
	.address_bus_enable_i(address_bus_enable_i), .bus_mode_i(bus_mode_i),
	.core_clock_strap_i(core_clock_strap_i), .core_clock_cfg_o(core_clock_cfg_o),
	.address_o(address_o), .access_size_lanes_o(access_size_lanes_o),
	.addr_phase_oe_o(addr_phase_oe_o));

`default_nettype wire
